// ==== design/ilsr_pkg.sv ====
// package: offsets, reset values, field layout and factor table for the ideality and limit status slice
package ilsr_pkg;
  // register offsets on the management bus
  localparam logic [7:0] ILSR_ADDR_EXT1_IDEAL = 8'h27;
  localparam logic [7:0] ILSR_ADDR_EXT2_IDEAL = 8'h28;
  localparam logic [7:0] ILSR_ADDR_EXT3_IDEAL = 8'h31;
  localparam logic [7:0] ILSR_ADDR_HIGH_FLAGS = 8'h35;
  localparam logic [7:0] ILSR_ADDR_LOW_FLAGS = 8'h36;
  // field widths and reset values
  localparam int ILSR_CODE_W = 6;
  localparam int ILSR_NCHAN = 3;
  localparam int ILSR_NEXT = 3;
  localparam logic [5:0] ILSR_CODE_RESET = 6'h12;
  localparam logic [2:0] ILSR_FLAGS_RESET = 3'h0;
  // channel bit positions inside the flag registers
  localparam int ILSR_BIT_INTERNAL = 0;
  localparam int ILSR_BIT_EXT1 = 1;
  localparam int ILSR_BIT_EXT2 = 2;
  // correction codes covered by the factor table
  localparam logic [5:0] ILSR_CODE_MIN = 6'h08;
  localparam logic [5:0] ILSR_CODE_MAX = 6'h37;
  localparam int ILSR_LUT_N = 48;
  // transistor-model factors sit a constant 0.0080 below the diode-model ones
  localparam logic [15:0] ILSR_BJT_OFFSET = 16'h0050;
  // diode-model factor, in units of 0.0001, for codes 08h..37h
  localparam logic [15:0] ILSR_DIODE_LUT [ILSR_LUT_N] = '{
    16'd9949, 16'd9962, 16'd9975, 16'd9988, 16'd10001, 16'd10014, 16'd10027, 16'd10040,
    16'd10053, 16'd10066, 16'd10080, 16'd10093, 16'd10106, 16'd10119, 16'd10133, 16'd10146,
    16'd10159, 16'd10172, 16'd10185, 16'd10200, 16'd10212, 16'd10226, 16'd10239, 16'd10253,
    16'd10267, 16'd10280, 16'd10293, 16'd10306, 16'd10319, 16'd10332, 16'd10345, 16'd10358,
    16'd10371, 16'd10384, 16'd10397, 16'd10410, 16'd10423, 16'd10436, 16'd10449, 16'd10462,
    16'd10475, 16'd10488, 16'd10501, 16'd10514, 16'd10527, 16'd10540, 16'd10553, 16'd10566};
  // register bus request carried as one bundle
  typedef struct packed {
    logic [7:0] addr;
    logic wr_en;
    logic rd_en;
    logic [7:0] wr_data;
  } ilsr_req_t;
  // per-channel limit events and levels from the measurement engine
  typedef struct packed {
    logic [2:0] high_set;
    logic [2:0] low_set;
    logic [2:0] high_cond;
    logic [2:0] low_cond;
  } ilsr_limit_t;
endpackage : ilsr_pkg

// ==== design/ilsr_regs.sv ====
// ideality correction settings and clear-on-read limit status registers
// Behaviour
// - three read/write 6-bit ideality codes, reset 12h
// - diode table maps codes 08h-37h, 12h=1.0080
// - transistor table over same codes, 12h=1.0000
// - high flags at bits 2,1,0 per channel
// - any high flag sets high summary
// - reading high register clears flags and summary in interrupt mode
// - alarm needs count met and a flag
// - interrupt mode latches; comparator mode follows condition
// - low flag set below low limit
// - any low flag sets low summary
// - reading low register clears its flags in interrupt mode
// - reading low register clears low summary in interrupt mode
// - low flags at bits 2,1,0 per channel
// - count reached with a flag set raises alarm; flags come only from limit events and levels
`timescale 1ns/1ps
`default_nettype none
module ilsr_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register port
  input wire ilsr_pkg::ilsr_req_t req,
  output logic [7:0] rd_data,
  // measurement engine side
  input wire ilsr_pkg::ilsr_limit_t limit,
  input wire logic comparator_mode,
  input wire logic alert_count_met,
  input wire logic [2:0] bjt_model,
  // outputs to conversion logic and pins
  output logic [15:0] ext_factor [3],
  output logic high_summary,
  output logic low_summary,
  output logic alarm
);

  // factor lookup; codes outside the table clamp to its ends
  function automatic logic [15:0] ilsr_factor(input logic [5:0] code, input logic bjt);
    logic [5:0] c;
    logic [5:0] idx;
    logic [15:0] f;
    c = code;
    if (c < ilsr_pkg::ILSR_CODE_MIN)
    begin
      c = ilsr_pkg::ILSR_CODE_MIN;
    end
    else if (c > ilsr_pkg::ILSR_CODE_MAX)
    begin
      c = ilsr_pkg::ILSR_CODE_MAX;
    end
    idx = c - ilsr_pkg::ILSR_CODE_MIN;
    f = ilsr_pkg::ILSR_DIODE_LUT[idx];
    if (bjt)
    begin
      f = f - ilsr_pkg::ILSR_BJT_OFFSET;
    end
    return f;
  endfunction : ilsr_factor

  logic [5:0] code [3];
  logic [2:0] high_flags;
  logic [2:0] low_flags;
  logic [7:0] next_rd_data;
  logic [2:0] next_high_flags;
  logic [2:0] next_low_flags;

  // address decode
  wire hit_e1 = req.addr == ilsr_pkg::ILSR_ADDR_EXT1_IDEAL;
  wire hit_e2 = req.addr == ilsr_pkg::ILSR_ADDR_EXT2_IDEAL;
  wire hit_e3 = req.addr == ilsr_pkg::ILSR_ADDR_EXT3_IDEAL;
  wire hit_hi = req.addr == ilsr_pkg::ILSR_ADDR_HIGH_FLAGS;
  wire hit_lo = req.addr == ilsr_pkg::ILSR_ADDR_LOW_FLAGS;
  wire [2:0] code_we = {3{req.wr_en}} & {hit_e3, hit_e2, hit_e1};
  wire clr_hi = req.rd_en && hit_hi;
  wire clr_lo = req.rd_en && hit_lo;

  // only the low six bits are kept, so the upper two always read zero
  genvar g;
  generate
    for (g = 0; g < ilsr_pkg::ILSR_NEXT; g++)
    begin : g_code
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
          code[g] <= ilsr_pkg::ILSR_CODE_RESET;
        else if (code_we[g])
          code[g] <= req.wr_data[5:0];
      end
      // factor registered so the conversion sees a glitch-free value
      always_ff @(posedge clock or negedge rst_b)
      begin
        // reset loads a plain table constant so the reset branch holds no logic
        if (!rst_b)
          ext_factor[g] <= ilsr_pkg::ILSR_DIODE_LUT[ilsr_pkg::ILSR_CODE_RESET - ilsr_pkg::ILSR_CODE_MIN];
        else
          ext_factor[g] <= ilsr_factor(code[g], bjt_model[g]);
      end
    end
  endgenerate

  // flag update: comparator mode tracks the level, interrupt mode latches;
  // the set term is or-ed after the clear so a same-cycle event survives
  // and bus writes never reach the flags
  assign next_high_flags = comparator_mode ? limit.high_cond :
                           ((clr_hi ? 3'h0 : high_flags) | limit.high_set);
  assign next_low_flags = comparator_mode ? limit.low_cond :
                          ((clr_lo ? 3'h0 : low_flags) | limit.low_set);

  // read mux; unmapped offsets answer zero
  assign next_rd_data = hit_e1 ? {2'h0, code[0]} :
                        hit_e2 ? {2'h0, code[1]} :
                        hit_e3 ? {2'h0, code[2]} :
                        hit_hi ? {5'h00, high_flags} :
                        hit_lo ? {5'h00, low_flags} : 8'h00;

  // status flags and summaries
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      high_flags <= ilsr_pkg::ILSR_FLAGS_RESET;
      low_flags <= ilsr_pkg::ILSR_FLAGS_RESET;
      high_summary <= 1'b0;
      low_summary <= 1'b0;
    end
    else
    begin
      high_flags <= next_high_flags;
      low_flags <= next_low_flags;
      high_summary <= |next_high_flags;
      low_summary <= |next_low_flags;
    end
  end

  // read data captured on the read strobe, held otherwise
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rd_data <= 8'h00;
    else if (req.rd_en)
      rd_data <= next_rd_data;
  end

  // alarm uses the next flag state so it rises with the flag, not a cycle late
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      alarm <= 1'b0;
    else
      alarm <= alert_count_met && (|next_high_flags || |next_low_flags);
  end

  // checks
  property p_code_reset_read;
    @(posedge clock) disable iff (!rst_b) req.rd_en && hit_e1 && !req.wr_en |=> rd_data[7:6] == 2'h0;
  endproperty
  a_code_reset_read: assert property (p_code_reset_read) else $error("ideality read upper bits nonzero");
  property p_code_write;
    @(posedge clock) disable iff (!rst_b) req.wr_en && hit_e2 |=> code[1] == $past(req.wr_data[5:0]);
  endproperty
  a_code_write: assert property (p_code_write) else $error("ideality code not stored");
  property p_factor_default;
    @(posedge clock) disable iff (!rst_b) code[0] == 6'h12 && !bjt_model[0] ##1 code[0] == 6'h12
      |-> ext_factor[0] == 16'd10080;
  endproperty
  a_factor_default: assert property (p_factor_default) else $error("diode factor for 12h wrong");
  property p_factor_bjt;
    @(posedge clock) disable iff (!rst_b) code[2] == 6'h37 && bjt_model[2] |=> ext_factor[2] == 16'd10486;
  endproperty
  a_factor_bjt: assert property (p_factor_bjt) else $error("transistor factor for 37h wrong");
  property p_high_set;
    @(posedge clock) disable iff (!rst_b) !comparator_mode && limit.high_set[2] |=> high_flags[2] && high_summary;
  endproperty
  a_high_set: assert property (p_high_set) else $error("high flag or summary not set");
  property p_high_clear;
    @(posedge clock) disable iff (!rst_b) !comparator_mode && clr_hi && limit.high_set == 3'h0
      |=> high_flags == 3'h0 && !high_summary;
  endproperty
  a_high_clear: assert property (p_high_clear) else $error("high read did not clear");
  property p_low_clear;
    @(posedge clock) disable iff (!rst_b) !comparator_mode && clr_lo && limit.low_set == 3'h0
      |=> low_flags == 3'h0 && !low_summary;
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low read did not clear");
  property p_set_wins;
    @(posedge clock) disable iff (!rst_b) !comparator_mode && clr_lo && limit.low_set[0] |=> low_flags[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost against clearing read");
  property p_latch;
    @(posedge clock) disable iff (!rst_b) !comparator_mode && high_flags[1] && !clr_hi ##0 !comparator_mode [*1]
      |=> high_flags[1];
  endproperty
  a_latch: assert property (p_latch) else $error("latched flag dropped without read");
  property p_follow;
    @(posedge clock) disable iff (!rst_b) comparator_mode |=> low_flags == $past(limit.low_cond);
  endproperty
  a_follow: assert property (p_follow) else $error("comparator flags not following");
  property p_alarm;
    @(posedge clock) disable iff (!rst_b) alarm |-> $past(alert_count_met) && (high_summary || low_summary);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without count and flag");
  property p_write_no_flag;
    @(posedge clock) disable iff (!rst_b) !comparator_mode && req.wr_en && hit_lo && !req.rd_en
      && limit.low_set == 3'h0 |=> low_flags == $past(low_flags);
  endproperty
  a_write_no_flag: assert property (p_write_no_flag) else $error("write changed flags");
  // set paths of the low register and the alarm, which the clearing checks above do not reach
  property p_low_set;
    @(posedge clock) disable iff (!rst_b) !comparator_mode && limit.low_set[1] |=> low_flags[1] && low_summary;
  endproperty
  a_low_set: assert property (p_low_set) else $error("low flag or summary not set");
  property p_alarm_rise;
    @(posedge clock) disable iff (!rst_b) !comparator_mode && alert_count_met && limit.high_set != 3'h0 |=> alarm;
  endproperty
  a_alarm_rise: assert property (p_alarm_rise) else $error("alarm missing after count reached");
  // main scenarios: alarm, clearing read, set racing a read, comparator tracking
  c_alarm: cover property (@(posedge clock) disable iff (!rst_b) alert_count_met && limit.high_set != 3'h0 ##1 alarm);
  c_clear: cover property (@(posedge clock) disable iff (!rst_b) high_summary ##1 clr_hi ##1 !high_summary);
  c_race: cover property (@(posedge clock) disable iff (!rst_b) clr_lo && limit.low_set != 3'h0);
  c_follow: cover property (@(posedge clock) disable iff (!rst_b)
    comparator_mode && limit.high_cond != 3'h0 ##1 high_summary);
endmodule : ilsr_regs
`default_nettype wire

// ==== bench/ilsr_host.sv ====
// host model that drives the register port one access at a time
`timescale 1ns/1ps
`default_nettype none
module ilsr_host (
  // clock
  input wire logic clock,
  // register port
  output var ilsr_pkg::ilsr_req_t req
);
  initial req = '0;
  // strobe held one cycle; released lines show the inverse so stale values never look valid
  // ideality codes are only touched when a scenario asks for it
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wr_en: w, rd_en: !w, wr_data: d};
    @(posedge clock);
    req <= '{addr: ~a, wr_en: 1'b0, rd_en: 1'b0, wr_data: ~d};
  endtask : xfer
endmodule : ilsr_host
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the ideality and limit status registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] hi = ilsr_pkg::ILSR_ADDR_HIGH_FLAGS;
  localparam logic [7:0] lo = ilsr_pkg::ILSR_ADDR_LOW_FLAGS;
  localparam logic [7:0] ideal_addr [3] = '{8'h27, 8'h28, 8'h31};
  localparam logic [5:0] codes [4] = '{6'h08, 6'h37, 6'h15, 6'h12};
  // diode factors 9949, 10566, 10119, 10080
  localparam logic [15:0] dio [4] = '{16'h26dd, 16'h2946, 16'h2787, 16'h2760};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  ilsr_pkg::ilsr_req_t req;
  ilsr_pkg::ilsr_limit_t limit = '0;
  logic comparator_mode = 1'b0;
  logic alert_count_met = 1'b1;
  logic [2:0] bjt_model = 3'h0;
  logic [7:0] rd_data;
  logic [15:0] ext_factor [3];
  logic high_summary;
  logic low_summary;
  logic alarm;
  logic rd_taken = 1'b0;
  logic [7:0] exp_q [$];
  int fails = 0;
  int total_checks = 0;
  int seed = 13;
  always #10 clock = ~clock;
  ilsr_regs dut_u (.clock(clock), .rst_b(rst_b), .req(req), .rd_data(rd_data), .limit(limit),
    .comparator_mode(comparator_mode), .alert_count_met(alert_count_met), .bjt_model(bjt_model),
    .ext_factor(ext_factor), .high_summary(high_summary), .low_summary(low_summary), .alarm(alarm));
  ilsr_host host_u (.clock(clock), .req(req));
  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    total_checks++;
    if (seen !== expd)
    begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  // note the expected byte before the read goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.xfer(a, 1'b0, 8'h00);
  endtask : rd
  // one-cycle event pulse from the measurement side, then settle
  task automatic pulse(input logic [2:0] hs, input logic [2:0] ls);
    @(posedge clock);
    limit.high_set <= hs;
    limit.low_set <= ls;
    @(posedge clock);
    limit.high_set <= 3'h0;
    limit.low_set <= 3'h0;
    @(negedge clock);
  endtask : pulse
  // read answers land on the edge that takes the strobe and are checked at the falling edge after it
  always @(posedge clock) rd_taken <= req.rd_en;
  always @(negedge clock)
    if (rd_taken === 1'b1 && exp_q.size() > 0)
      check(rd_data, exp_q.pop_front());
  // hang guard, well beyond the roughly 160 cycles the sequence needs
  initial
  begin
    #100000;
    fails++;
    give_verdict();
  end
  initial
  begin
    logic [7:0] r;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    for (int ch = 0; ch < 3; ch++)
    begin
      check(ext_factor[ch], 16'h2760);
      rd(ideal_addr[ch], 8'h12);
    end
    foreach (codes[i])
      for (int ch = 0; ch < 3; ch++)
      begin
        r = 8'($random(seed));
        bjt_model[ch] <= r[0];
        host_u.xfer(ideal_addr[ch], 1'b1, {r[7:6], codes[i]});
        repeat (3) @(posedge clock);
        @(negedge clock);
        check(ext_factor[ch], r[0] ? dio[i] - 16'h0050 : dio[i]);
        rd(ideal_addr[ch], {2'b00, codes[i]});
      end
    // transistor table on every channel, 12h must give unity and 37h the top entry
    bjt_model <= 3'h7;
    host_u.xfer(ideal_addr[2], 1'b1, 8'h37);
    repeat (3) @(posedge clock);
    @(negedge clock);
    check(ext_factor[0], 16'h2710);
    check(ext_factor[2], 16'h28f6);
    rd(8'h40, 8'h00);
    for (int ch = 0; ch < 3; ch++)
    begin
      pulse(3'h1 << ch, 3'h0);
      check({high_summary, low_summary, alarm}, 16'h5);
      host_u.xfer(hi, 1'b1, 8'h00);
      rd(hi, 8'h01 << ch);
      @(negedge clock);
      check({high_summary, alarm}, 16'h0);
      pulse(3'h0, 3'h1 << ch);
      check({high_summary, low_summary, alarm}, 16'h3);
      host_u.xfer(lo, 1'b1, 8'hff);
      rd(lo, 8'h01 << ch);
      @(negedge clock);
      check(low_summary, 16'h0);
    end
    pulse(3'h1, 3'h0);
    exp_q.push_back(8'h01);
    fork
      host_u.xfer(hi, 1'b0, 8'h00);
      pulse(3'h4, 3'h0);
    join
    rd(hi, 8'h04);
    // same race on the low register: the read sees nothing, the new flag survives it
    exp_q.push_back(8'h00);
    fork
      host_u.xfer(lo, 1'b0, 8'h00);
      pulse(3'h0, 3'h1);
    join
    rd(lo, 8'h01);
    alert_count_met <= 1'b0;
    pulse(3'h0, 3'h2);
    check({low_summary, alarm}, 16'h2);
    rd(lo, 8'h02);
    comparator_mode <= 1'b1;
    limit.high_cond <= 3'h5;
    limit.low_cond <= 3'h2;
    pulse(3'h2, 3'h4);
    check({high_summary, low_summary}, 16'h3);
    rd(hi, 8'h05);
    rd(lo, 8'h02);
    @(negedge clock);
    check(high_summary, 16'h1);
    @(posedge clock);
    limit.high_cond <= 3'h0;
    limit.low_cond <= 3'h0;
    repeat (2) @(negedge clock);
    check({high_summary, low_summary}, 16'h0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
